// file: common/pcb_pkg.sv
// ============================================================
// Shared constants for the pwm channel configuration bank
package pcb_pkg;
   localparam int unsigned NUM_CH     = 8;
   localparam int unsigned ADDR_W     = 8;
   localparam int unsigned DATA_W     = 32;
   localparam int unsigned REG_W      = 8;
   localparam int unsigned PRESC_W    = 7;
   localparam int unsigned RATE_W     = 3;
   localparam int unsigned JOIN_W     = 4;

   // ============================================================
   // Register byte addresses
   localparam logic [ADDR_W-1:0] OFS_CHANNEL_ENABLE   = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_CHANNEL_POLARITY = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_CLOCK_SELECT     = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_AB_SWAP          = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_PRESCALE_SELECT  = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_CENTER_ALIGN     = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_JOIN_CONTROL     = 8'h18;

   // ============================================================
   // Field layout and variant shape
   // Channels built on this variant; others discard writes and read zero
   localparam logic [REG_W-1:0]  CHAN_PRESENT  = 8'h3f;
   // Channels 0,1,4,5 take clock A first, the rest clock B first
   localparam logic [REG_W-1:0]  CH_A_FIRST    = 8'h33;
   localparam int unsigned       RATE_A_LSB    = 0;
   localparam int unsigned       RATE_B_LSB    = 4;
   localparam int unsigned       JOIN_LSB      = 4;
   localparam logic [REG_W-1:0]  PRESC_MASK    = 8'h77;
   localparam logic [JOIN_W-1:0] JOIN_PRESENT  = {&CHAN_PRESENT[7:6], &CHAN_PRESENT[5:4],
                                                  &CHAN_PRESENT[3:2], &CHAN_PRESENT[1:0]};
   localparam logic [REG_W-1:0]  JOIN_MASK     = {JOIN_PRESENT, 4'h0};
   localparam logic [REG_W-1:0]  REG_RST       = 8'h00;
   localparam logic [PRESC_W-1:0] PRESC_RST    = 7'h00;
   localparam logic [PRESC_W-1:0] PRESC_FULL   = 7'h7f;

   // ============================================================
   // AXI4-Lite answers
   localparam logic [1:0]        RESP_OKAY     = 2'h0;
   localparam logic [1:0]        RESP_SLVERR   = 2'h2;
endpackage : pcb_pkg

// file: core/pcb_config_bank.sv
// The implementer's own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
module pcb_config_bank
   import pcb_pkg::*;
(
   input  wire logic                clock,
   input  wire logic                nrst,
   input  wire logic                ce,
   input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [DATA_W-1:0]   s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [ADDR_W-1:0]   s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [DATA_W-1:0]        s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   input  wire logic [NUM_CH-1:0]   wave_before_duty,
   input  wire logic                scaled_clock_a,
   input  wire logic                scaled_clock_b,
   output logic [NUM_CH-1:0]        pwm_pin,
   output logic [NUM_CH-1:0]        chan_active,
   output logic [NUM_CH-1:0]        chan_tick,
   output logic                     clk_a_tick,
   output logic                     clk_b_tick,
   output logic [NUM_CH-1:0]        center_align_bits,
   output logic [JOIN_W-1:0]        join_pairs
);

   // ============================================================
   // Reset release
   logic [1:0]          rst_sync_ff;
   logic                rst_n;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rst_sync_ff <= 2'h0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_ff[1];

   // ============================================================
   // Register bus and configuration registers
   logic                aw_held_ff, nxt_aw_held;
   logic                w_held_ff, nxt_w_held;
   logic [ADDR_W-1:0]   waddr_ff, nxt_waddr;
   logic [REG_W-1:0]    wdata_ff, nxt_wdata;
   logic                wlane_ff, nxt_wlane;
   logic                awready_ff, nxt_awready;
   logic                wready_ff, nxt_wready;
   logic                bvalid_ff, nxt_bvalid;
   logic [1:0]          bresp_ff, nxt_bresp;
   logic                arready_ff, nxt_arready;
   logic                rvalid_ff, nxt_rvalid;
   logic [1:0]          rresp_ff, nxt_rresp;
   logic [REG_W-1:0]    rdata_ff, nxt_rdata;
   logic [REG_W-1:0]    en_ff, nxt_en;
   logic [REG_W-1:0]    pol_ff, nxt_pol;
   logic [REG_W-1:0]    csel_ff, nxt_csel;
   logic [REG_W-1:0]    swap_ff, nxt_swap;
   logic [REG_W-1:0]    presc_ff, nxt_presc;
   logic [REG_W-1:0]    align_ff, nxt_align;
   logic [REG_W-1:0]    join_ff, nxt_join;
   logic                wr_fire;
   logic                wr_hit;

   always_comb begin
      nxt_aw_held = aw_held_ff;
      nxt_w_held  = w_held_ff;
      nxt_waddr   = waddr_ff;
      nxt_wdata   = wdata_ff;
      nxt_wlane   = wlane_ff;
      nxt_bvalid  = bvalid_ff;
      nxt_bresp   = bresp_ff;
      nxt_rvalid  = rvalid_ff;
      nxt_rresp   = rresp_ff;
      nxt_rdata   = rdata_ff;
      nxt_en      = en_ff;
      nxt_pol     = pol_ff;
      nxt_csel    = csel_ff;
      nxt_swap    = swap_ff;
      nxt_presc   = presc_ff;
      nxt_align   = align_ff;
      nxt_join    = join_ff;
      wr_hit      = 1'b1;
      wr_fire     = aw_held_ff && w_held_ff && !bvalid_ff;
      if (s_axi_awvalid && awready_ff) begin
         nxt_aw_held = 1'b1;
         nxt_waddr   = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_ff) begin
         nxt_w_held = 1'b1;
         nxt_wdata  = s_axi_wdata[REG_W-1:0];
         nxt_wlane  = s_axi_wstrb[0];
      end
      if (s_axi_bvalid && s_axi_bready) begin
         nxt_bvalid = 1'b0;
      end
      // Writes land with no regard to channel state; glitches are accepted
      if (wr_fire) begin
         nxt_aw_held = 1'b0;
         nxt_w_held  = 1'b0;
         nxt_bvalid  = 1'b1;
         unique case (waddr_ff)
            OFS_CHANNEL_ENABLE:   if (wlane_ff) nxt_en    = wdata_ff & CHAN_PRESENT;
            OFS_CHANNEL_POLARITY: if (wlane_ff) nxt_pol   = wdata_ff & CHAN_PRESENT;
            OFS_CLOCK_SELECT:     if (wlane_ff) nxt_csel  = wdata_ff & CHAN_PRESENT;
            OFS_AB_SWAP:          if (wlane_ff) nxt_swap  = wdata_ff & CHAN_PRESENT;
            OFS_PRESCALE_SELECT:  if (wlane_ff) nxt_presc = wdata_ff & PRESC_MASK;
            OFS_CENTER_ALIGN:     if (wlane_ff) nxt_align = wdata_ff & CHAN_PRESENT;
            OFS_JOIN_CONTROL:     if (wlane_ff) nxt_join  = wdata_ff & JOIN_MASK;
            default:              wr_hit = 1'b0;
         endcase
         nxt_bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
         nxt_rvalid = 1'b0;
      end
      if (s_axi_arvalid && arready_ff) begin
         nxt_rvalid = 1'b1;
         nxt_rresp  = RESP_OKAY;
         unique case (s_axi_araddr)
            OFS_CHANNEL_ENABLE:   nxt_rdata = en_ff;
            OFS_CHANNEL_POLARITY: nxt_rdata = pol_ff;
            OFS_CLOCK_SELECT:     nxt_rdata = csel_ff;
            OFS_AB_SWAP:          nxt_rdata = swap_ff;
            OFS_PRESCALE_SELECT:  nxt_rdata = presc_ff;
            OFS_CENTER_ALIGN:     nxt_rdata = align_ff;
            OFS_JOIN_CONTROL:     nxt_rdata = join_ff;
            default: begin
               nxt_rdata = REG_RST;
               nxt_rresp = RESP_SLVERR;
            end
         endcase
      end
      nxt_awready = !nxt_aw_held && !nxt_bvalid;
      nxt_wready  = !nxt_w_held && !nxt_bvalid;
      nxt_arready = !nxt_rvalid;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         aw_held_ff <= 1'b0;
         w_held_ff  <= 1'b0;
         waddr_ff   <= '0;
         wdata_ff   <= REG_RST;
         wlane_ff   <= 1'b0;
         awready_ff <= 1'b0;
         wready_ff  <= 1'b0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= RESP_OKAY;
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b0;
         rresp_ff   <= RESP_OKAY;
         rdata_ff   <= REG_RST;
         en_ff      <= REG_RST;
         pol_ff     <= REG_RST;
         csel_ff    <= REG_RST;
         swap_ff    <= REG_RST;
         presc_ff   <= REG_RST;
         align_ff   <= REG_RST;
         join_ff    <= REG_RST;
      end else if (ce) begin
         aw_held_ff <= nxt_aw_held;
         w_held_ff  <= nxt_w_held;
         waddr_ff   <= nxt_waddr;
         wdata_ff   <= nxt_wdata;
         wlane_ff   <= nxt_wlane;
         awready_ff <= nxt_awready;
         wready_ff  <= nxt_wready;
         bvalid_ff  <= nxt_bvalid;
         bresp_ff   <= nxt_bresp;
         arready_ff <= nxt_arready;
         rvalid_ff  <= nxt_rvalid;
         rresp_ff   <= nxt_rresp;
         rdata_ff   <= nxt_rdata;
         en_ff      <= nxt_en;
         pol_ff     <= nxt_pol;
         csel_ff    <= nxt_csel;
         swap_ff    <= nxt_swap;
         presc_ff   <= nxt_presc;
         align_ff   <= nxt_align;
         join_ff    <= nxt_join;
      end
   end

   assign s_axi_awready = awready_ff;
   assign s_axi_wready  = wready_ff;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rresp   = rresp_ff;
   assign s_axi_rdata   = {{(DATA_W-REG_W){1'b0}}, rdata_ff};

   // ============================================================
   // Prescaler, source selection and output gating
   logic [PRESC_W-1:0]  cnt_ff, nxt_cnt;
   logic [RATE_W-1:0]   rate_field_a, rate_field_b;
   logic [PRESC_W-1:0]  mask_a, mask_b;
   logic                tick_a, tick_b;
   logic                clk_a_ff, clk_b_ff;
   logic [NUM_CH-1:0]   join_even, eff_en, sel_tick;
   logic [NUM_CH-1:0]   active_ff, nxt_active;
   logic [NUM_CH-1:0]   tick_ff, pin_ff, nxt_pin;
   logic                run;
   logic                use_b;

   assign rate_field_a = presc_ff[RATE_A_LSB +: RATE_W];
   assign rate_field_b = presc_ff[RATE_B_LSB +: RATE_W];
   assign run          = |en_ff;
   // A code of n fires once every 2**n bus clocks
   assign mask_a       = PRESC_FULL >> (PRESC_W - rate_field_a);
   assign mask_b       = PRESC_FULL >> (PRESC_W - rate_field_b);
   assign tick_a       = run && ((cnt_ff & mask_a) == mask_a);
   assign tick_b       = run && ((cnt_ff & mask_b) == mask_b);

   always_comb begin
      // Only the odd channel of a joined pair may run; the even one stays off
      for (int p = 0; p < JOIN_W; p++) begin
         join_even[2*p]   = join_ff[JOIN_LSB+p];
         join_even[2*p+1] = 1'b0;
      end
      eff_en = en_ff & ~join_even;
      for (int i = 0; i < NUM_CH; i++) begin
         use_b = swap_ff[i] ^ ~CH_A_FIRST[i];
         if (csel_ff[i]) begin
            sel_tick[i] = use_b ? scaled_clock_b : scaled_clock_a;
         end else begin
            sel_tick[i] = use_b ? tick_b : tick_a;
         end
      end
      nxt_cnt = run ? (cnt_ff + 7'h01) : PRESC_RST;
      // Enable waits for the source tick so the first period starts cleanly
      nxt_active = (active_ff | (eff_en & sel_tick)) & eff_en;
      nxt_pin    = nxt_active & ~(wave_before_duty ^ pol_ff);
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff    <= PRESC_RST;
         clk_a_ff  <= 1'b0;
         clk_b_ff  <= 1'b0;
         active_ff <= REG_RST;
         tick_ff   <= REG_RST;
         pin_ff    <= REG_RST;
      end else if (ce) begin
         cnt_ff    <= nxt_cnt;
         clk_a_ff  <= tick_a;
         clk_b_ff  <= tick_b;
         active_ff <= nxt_active;
         tick_ff   <= sel_tick;
         pin_ff    <= nxt_pin;
      end
   end

   assign pwm_pin           = pin_ff;
   assign chan_active       = active_ff;
   assign chan_tick         = tick_ff;
   assign clk_a_tick        = clk_a_ff;
   assign clk_b_tick        = clk_b_ff;
   assign center_align_bits = align_ff;
   assign join_pairs        = join_ff[JOIN_LSB +: JOIN_W];

   // ============================================================
   // Checks
   a_start_on_tick: assert property (@(posedge clock) disable iff (!rst_n)
      ce |=> ((active_ff & ~$past(active_ff) & ~$past(sel_tick)) == 8'h00))
      else $error("channel started without a source tick");
   a_disabled_quiet: assert property (@(posedge clock) disable iff (!rst_n)
      ce && (eff_en == 8'h00) |=> (pin_ff == 8'h00) && (active_ff == 8'h00))
      else $error("disabled channel still drives its pin");
   a_join_even_off: assert property (@(posedge clock) disable iff (!rst_n)
      ce |=> ((pin_ff & $past(join_even)) == 8'h00))
      else $error("even channel of a joined pair is active");
   a_unbuilt_zero: assert property (@(posedge clock) disable iff (!rst_n)
      ((en_ff | pol_ff | csel_ff | align_ff) & ~CHAN_PRESENT) == 8'h00)
      else $error("unbuilt channel bit holds a one");
   a_polarity_level: assert property (@(posedge clock) disable iff (!rst_n)
      ce && active_ff[1] && eff_en[1] && wave_before_duty[1] |=> pin_ff[1] == $past(pol_ff[1]))
      else $error("pin level before duty count disagrees with polarity");
   a_src_ch0: assert property (@(posedge clock) disable iff (!rst_n)
      ce && !swap_ff[0] && !csel_ff[0] |=> tick_ff[0] == $past(tick_a))
      else $error("channel 0 not fed from clock A");
   a_src_ch2: assert property (@(posedge clock) disable iff (!rst_n)
      ce && !swap_ff[2] && csel_ff[2] |=> tick_ff[2] == $past(scaled_clock_b))
      else $error("channel 2 not fed from scaled clock B");
   a_rate_undiv: assert property (@(posedge clock) disable iff (!rst_n)
      ce && run && (rate_field_b == 3'h0) |=> clk_b_ff)
      else $error("clock B with code zero is not undivided");
   a_rate_div2: assert property (@(posedge clock) disable iff (!rst_n)
      ce && run && (rate_field_a == 3'h1) && tick_a |=> !tick_a || !ce || (rate_field_a != 3'h1))
      else $error("clock A with code one fires on two neighbours");
   a_presc_stop: assert property (@(posedge clock) disable iff (!rst_n)
      ce && !run |=> (cnt_ff == PRESC_RST) && !clk_a_ff && !clk_b_ff)
      else $error("prescaler runs with every channel disabled");
   a_bvalid_hold: assert property (@(posedge clock) disable iff (!rst_n)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped before taken");

   c_write_done: cover property (@(posedge clock) disable iff (!rst_n)
      s_axi_bvalid && s_axi_bready && (s_axi_bresp == RESP_OKAY));
   c_read_done: cover property (@(posedge clock) disable iff (!rst_n)
      s_axi_rvalid && s_axi_rready);
   c_chan_start: cover property (@(posedge clock) disable iff (!rst_n)
      $rose(active_ff[1]));
   c_joined_run: cover property (@(posedge clock) disable iff (!rst_n)
      join_ff[JOIN_LSB] && active_ff[1]);

endmodule : pcb_config_bank

// file: tb/pcb_load_model.sv
`timescale 1ns/10ps
// ============================================================
// Far side: counter stage feeding duty state and scaled tick dividers
module pcb_load_model (
   input  wire logic       clock,
   input  wire logic       nrst,
   input  wire logic [7:0] pwm_pin,
   output logic [7:0]      wave_before_duty,
   output logic            scaled_clock_a,
   output logic            scaled_clock_b
);
   logic [7:0] cnt_ff;
   logic [7:0] nxt_cnt;
   logic [7:0] nxt_wave;

   // Duty differs per channel so every pin sees both levels
   always_comb begin
      nxt_cnt = cnt_ff + 8'h01;
      for (int i = 0; i < 8; i++) begin
         nxt_wave[i] = (cnt_ff[3:0] < 4'(2 * i + 1));
      end
   end

   // Scaled ticks have periods 3 and 5 so the bench can tell them apart
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         cnt_ff           <= 8'h00;
         wave_before_duty <= 8'h00;
         scaled_clock_a   <= 1'b0;
         scaled_clock_b   <= 1'b0;
      end else begin
         cnt_ff           <= nxt_cnt;
         wave_before_duty <= nxt_wave;
         scaled_clock_a   <= (cnt_ff % 3 == 0);
         scaled_clock_b   <= (cnt_ff % 5 == 0);
      end
   end
endmodule : pcb_load_model

// file: tb/testbench.sv
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin mismatches++; \
   $display("ERROR %s expected %h seen %h", nm, ex, got); end end

module testbench;
   import pcb_pkg::*;
   logic              clock = 1'b0;
   logic              nrst = 1'b0;
   logic              ce = 1'b1;
   logic [ADDR_W-1:0] aw_addr = '0, ar_addr = '0;
   logic [DATA_W-1:0] w_data = '0, r_data;
   logic [3:0]        w_strb = '0;
   logic              aw_valid = 0, w_valid = 0, b_ready = 0, ar_valid = 0, r_ready = 0;
   logic              aw_ready, w_ready, b_valid, ar_ready, r_valid;
   logic [1:0]        b_resp, r_resp, rsp;
   logic [7:0]        wave, pin, active, ctick, cab, joins;
   logic              sc_a, sc_b, ta, tb;
   logic [31:0]       d;
   int                mismatches = 0, samples_checked = 0;

   always #50 clock = ~clock;

   pcb_config_bank i_dut (.clock(clock), .nrst(nrst), .ce(ce),
      .s_axi_awaddr(aw_addr), .s_axi_awvalid(aw_valid), .s_axi_awready(aw_ready),
      .s_axi_wdata(w_data), .s_axi_wstrb(w_strb), .s_axi_wvalid(w_valid), .s_axi_wready(w_ready),
      .s_axi_bresp(b_resp), .s_axi_bvalid(b_valid), .s_axi_bready(b_ready),
      .s_axi_araddr(ar_addr), .s_axi_arvalid(ar_valid), .s_axi_arready(ar_ready),
      .s_axi_rdata(r_data), .s_axi_rresp(r_resp), .s_axi_rvalid(r_valid), .s_axi_rready(r_ready),
      .wave_before_duty(wave), .scaled_clock_a(sc_a), .scaled_clock_b(sc_b), .pwm_pin(pin),
      .chan_active(active), .chan_tick(ctick), .clk_a_tick(ta), .clk_b_tick(tb),
      .center_align_bits(cab), .join_pairs(joins));

   pcb_load_model i_load (.clock(clock), .nrst(nrst), .pwm_pin(pin), .wave_before_duty(wave),
      .scaled_clock_a(sc_a), .scaled_clock_b(sc_b));

   // ============================================================
   // Bus master
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
      logic ad, dd;
      ad = 0;
      dd = 0;
      @(posedge clock);
      aw_addr <= a; w_data <= v; w_strb <= s; aw_valid <= 1; w_valid <= 1; b_ready <= 1;
      while (!(ad && dd)) begin
         @(posedge clock);
         if (aw_ready && !ad) begin ad = 1; aw_valid <= 0; end
         if (w_ready && !dd) begin dd = 1; w_valid <= 0; end
      end
      do @(posedge clock); while (!b_valid);
      rsp = b_resp;
      b_ready <= 0;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      @(posedge clock);
      ar_addr <= a; ar_valid <= 1; r_ready <= 1;
      do @(posedge clock); while (!ar_ready);
      ar_valid <= 0;
      do @(posedge clock); while (!r_valid);
      d = r_data;
      rsp = r_resp;
      r_ready <= 0;
   endtask : rd

   task automatic w(input logic [7:0] a, input logic [7:0] v);
      wr(a, {24'h0, v}, 4'hf);
      `CHK("write resp", RESP_OKAY, rsp)
   endtask : w

   // ============================================================
   // Scenarios
   task automatic t_regs();
      logic [7:0] ofs[7] = '{8'h14, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h18, 8'h00};
      logic [7:0] msk[7] = '{8'h3f, 8'h3f, 8'h3f, 8'h3f, 8'h77, 8'h70, 8'h3f};
      for (int i = 0; i < 7; i++) begin
         rd(ofs[i]);
         `CHK("reset value", 32'h0, d)
      end
      // Alignment is written first and cleared last, always with channels off
      for (int i = 0; i < 7; i++) begin
         w(ofs[i], 8'hff);
         rd(ofs[i]);
         `CHK("masked readback", {24'h0, msk[i]}, d)
      end
      wr(OFS_CHANNEL_ENABLE, 32'h0, 4'h0);
      rd(OFS_CHANNEL_ENABLE);
      `CHK("strobe off", 32'h3f, d)
      wr(8'h1c, 32'hff, 4'hf);
      `CHK("unmapped write", RESP_SLVERR, rsp)
      rd(8'h1c);
      `CHK("unmapped read", RESP_SLVERR, rsp)
      `CHK("unmapped data", 32'h0, d)
      for (int i = 6; i >= 0; i--) w(ofs[i], 8'h00);
   endtask : t_regs

   task automatic t_rate();
      int g, k;
      w(OFS_CHANNEL_ENABLE, 8'h01);
      for (int n = 0; n < 8; n++) begin
         w(OFS_PRESCALE_SELECT, 8'(n * 17));
         for (int b = 0; b < 2; b++) begin
            repeat (2) do @(posedge clock); while (!(b ? tb : ta));
            g = 0;
            do begin @(posedge clock); g++; end while (!(b ? tb : ta));
            `CHK("tick gap", 1 << n, g)
         end
      end
      w(OFS_PRESCALE_SELECT, 8'h11);
      w(OFS_CHANNEL_ENABLE, 8'h00);
      repeat (3) @(posedge clock);
      k = 0;
      repeat (20) begin @(posedge clock); k += ta; end
      `CHK("stopped prescaler", 0, k)
   endtask : t_rate

   task automatic t_src();
      // Ticks in 60 cycles for sources A, scaled A, B, scaled B
      int exp_ab[4] = '{60, 20, 15, 12};
      int c, e;
      w(OFS_PRESCALE_SELECT, 8'h20);
      w(OFS_CHANNEL_ENABLE, 8'h07);
      for (int ch = 1; ch < 3; ch++) begin
         for (int m = 0; m < 4; m++) begin
            w(OFS_CLOCK_SELECT, 8'((m & 1) << ch));
            w(OFS_AB_SWAP, 8'((m >> 1) << ch));
            repeat (4) @(posedge clock);
            c = 0;
            repeat (60) begin @(posedge clock); c += ctick[ch]; end
            e = (ch == 1) ? exp_ab[m] : exp_ab[m ^ 2];
            `CHK("source ticks", 1'b1, (c >= e - 1 && c <= e + 1))
         end
      end
      w(OFS_CLOCK_SELECT, 8'h00);
      w(OFS_AB_SWAP, 8'h00);
   endtask : t_src

   task automatic t_enable();
      int k;
      logic wv;
      w(OFS_CHANNEL_ENABLE, 8'h01);
      w(OFS_PRESCALE_SELECT, 8'h03);
      w(OFS_CHANNEL_ENABLE, 8'h03);
      k = 0;
      do begin @(negedge clock); k++; end while (!active[1] && k < 40);
      `CHK("start on tick", 1'b1, ctick[1])
      `CHK("start latency", 1'b1, k <= 12)
      w(OFS_PRESCALE_SELECT, 8'h00);
      for (int p = 1; p >= 0; p--) begin
         w(OFS_CHANNEL_POLARITY, 8'(p << 1));
         repeat (3) @(posedge clock);
         repeat (20) begin
            @(posedge clock);
            wv = wave[1];
            @(negedge clock);
            `CHK("pin level", ~(wv ^ 1'(p)), pin[1])
         end
      end
      w(OFS_CHANNEL_ENABLE, 8'h01);
      repeat (3) @(posedge clock);
      `CHK("disabled active", 1'b0, active[1])
      `CHK("disabled pin", 1'b0, pin[1])
   endtask : t_enable

   task automatic t_join();
      w(OFS_JOIN_CONTROL, 8'h10);
      repeat (10) @(posedge clock);
      `CHK("join pairs", 4'h1, joins)
      `CHK("even active", 1'b0, active[0])
      `CHK("even pin", 1'b0, pin[0])
      w(OFS_CHANNEL_ENABLE, 8'h02);
      repeat (10) @(posedge clock);
      `CHK("odd active", 1'b1, active[1])
      w(OFS_CHANNEL_ENABLE, 8'h00);
      w(OFS_JOIN_CONTROL, 8'h00);
      w(OFS_CENTER_ALIGN, 8'h2a);
      repeat (2) @(posedge clock);
      `CHK("align bits", 8'h2a, cab)
   endtask : t_join

   // Reset in mid-run with a channel running and alignment set
   task automatic t_reset();
      w(OFS_CHANNEL_ENABLE, 8'h02);
      repeat (2) @(posedge clock);
      `CHK("active before reset", 8'h02, active)
      nrst <= 1'b0;
      repeat (2) @(posedge clock);
      `CHK("active in reset", 8'h00, active)
      `CHK("pin in reset", 8'h00, pin)
      nrst <= 1'b1;
      repeat (4) @(posedge clock);
      rd(OFS_CENTER_ALIGN);
      `CHK("align after reset", 32'h0, d)
      rd(OFS_CHANNEL_ENABLE);
      `CHK("enable after reset", 32'h0, d)
   endtask : t_reset

   // Clock enable low must hold the prescaler; clock B at code one toggles every cycle
   task automatic t_freeze();
      logic v;
      w(OFS_PRESCALE_SELECT, 8'h10);
      w(OFS_CHANNEL_ENABLE, 8'h02);
      ce <= 1'b0;
      @(posedge clock);
      v = tb;
      repeat (6) begin
         @(posedge clock);
         `CHK("frozen tick", v, tb)
      end
      ce <= 1'b1;
      repeat (2) @(posedge clock);
      v = tb;
      @(posedge clock);
      `CHK("running tick", ~v, tb)
   endtask : t_freeze

   // ============================================================
   // Run control
   task automatic report_and_stop();
      $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : report_and_stop

   initial begin
      repeat (5) @(posedge clock);
      nrst <= 1'b1;
      repeat (4) @(posedge clock);
      t_regs();
      t_rate();
      t_src();
      t_enable();
      t_join();
      t_reset();
      t_freeze();
      report_and_stop();
   end

   // Longest scenario is the rate sweep, well under this span
   initial begin
      repeat (30000) @(posedge clock);
      mismatches++;
      report_and_stop();
   end
endmodule : testbench
